// *** ssp_checker.sv ***
// assertions on the pins of the sram pin-control block
`timescale 1ns/10ps
`default_nettype none
// ----------
// checker
// ----------
module ssp_checker
	import ssp_pkg::*;
(
	// clock, reset and pins
	input wire logic      clock,
	input wire logic      rst,
	input wire logic      clock_qualify_n,
	input wire logic      chip_sel_first_n,
	input wire logic      chip_sel_second,
	input wire logic      chip_sel_third_n,
	input wire logic      write_n,
	input wire logic      advance_or_load,
	input wire logic      output_enable_n,
	input wire ssp_pkg::ssp_word_t dq_out,
	input wire logic      dq_oe
);
	import ssp_pkg::*;

	// qualified edge, qualified load, full selection
	wire q = !clock_qualify_n;
	wire ld = q && !advance_or_load;
	wire sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_qual_hold: assert property (!q |=> $stable(dq_out))
		else $error("dq_out moved on a masked edge");
	a_out_cause: assert property (!$stable(dq_out) |-> $past(q))
		else $error("dq_out moved without a qualified edge");
	a_oe_off: assert property (output_enable_n [*4] |-> !dq_oe)
		else $error("pins driven with output enable high");
	a_hold_oe: assert property (
		(!q && !output_enable_n) [*4] |=> $stable(dq_oe))
		else $error("drive changed during a stretched cycle");
	a_desel_off: assert property (
		(ld && !sel) ##1 q [*2] |=> !dq_oe)
		else $error("pins driven after a deselect");
	a_write_off: assert property (
		(ld && sel && !write_n) ##1 q [*2] |=> !dq_oe)
		else $error("pins driven in a write data phase");
	a_adv_desel: assert property (
		(ld && !sel) ##1 (q && advance_or_load) ##1 q [*2] |=> !dq_oe)
		else $error("advance after deselect drove the pins");
	a_read_on: assert property (
		(!output_enable_n [*3] ##0 (ld && sel && write_n))
		##1 (q && !output_enable_n) [*2] |=> dq_oe)
		else $error("read data not driven");
endmodule : ssp_checker
`default_nettype wire

// *** ssp_ctl_model.sv ***
// controller model driving the sram command and data pins
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defines.svh"
// ----------
// controller
// ----------
module ssp_ctl_model
	import ssp_pkg::*;
(
	// clock
	input  wire logic                clock,
	// command pins
	output logic                     qn,
	output logic [2:0]               sel,
	output logic                     wr_n,
	output logic                     adv,
	output logic [`SSP_LANES-1:0]    bws_n,
	output logic [`SSP_AW-1:0]       a,
	// data pins
	output var ssp_pkg::ssp_word_t   dq
);
	import ssp_pkg::*;

	ssp_word_t p0, p1;
	initial begin
		qn = 1'h1;
		sel = 3'h6;
		{wr_n, adv, bws_n, a, p0, p1, dq} = '0;
	end
	// write data rides two qualified edges behind its command
	always @(posedge clock) if (!qn) begin
		p1 <= p0;
		dq <= p1;
	end
	// one command per call, changed just after an edge
	task automatic issue(input logic [2:0] s, input logic w, input logic v,
		input logic [`SSP_AW-1:0] ad, input logic [`SSP_LANES-1:0] b,
		input ssp_word_t d);
		@(posedge clock);
		qn <= 1'h0;
		sel <= s;
		wr_n <= ~w;
		adv <= v;
		a <= ad;
		bws_n <= b;
		p0 <= w ? d : ~p0; // no stale data on the lines
	endtask : issue
	// stretch with a bogus write on the pins, which must be ignored
	task automatic stall(input int n);
		@(posedge clock);
		qn <= 1'h1;
		wr_n <= 1'h0;
		adv <= 1'h0;
		repeat (n - 1) @(posedge clock);
	endtask : stall
endmodule : ssp_ctl_model
`default_nettype wire

// *** ssp_defines.svh ***
// constants of the synchronous sram pin-control block
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// ----------------------------------------------------------------
// organisation
// ----------------------------------------------------------------
`define SSP_LANE_W      8
`define SSP_LANES       4
`define SSP_DW          32
`define SSP_AW          10
`define SSP_DEPTH       1024
`define SSP_BURST_W     2

// ----------------------------------------------------------------
// reset values and read buffer depth
// ----------------------------------------------------------------
`define SSP_OE_N_RST    1'h1
`define SSP_MODE_RST    1'h1
`define SSP_WORD_RST    32'h00000000
`define SSP_BUF_DEPTH   2

`endif

// *** ssp_pin_control.sv ***
// pipelined synchronous burst sram core with its pin control
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defines.svh"

// ----------------------------------------------------------------
// two-entry buffer, valid and ready on both sides
// ----------------------------------------------------------------
module ssp_fifo2 #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          rst,
	// filling side
	input  wire logic          in_valid,
	output logic               in_ready,
	input  wire logic [W-1:0]  in_data,
	// draining side
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic [W-1:0]       out_data
);
	logic [W-1:0] store [0:1];
	logic         wptr;
	logic         rptr;
	logic [1:0]   count;

	// honest flags from the fill count
	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = store[rptr];

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	// pointers and count
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wptr  <= 1'h0;
			rptr  <= 1'h0;
			count <= 2'h0;
		end else begin
			wptr  <= wptr ^ push;
			rptr  <= rptr ^ pop;
			count <= count + {1'h0, push} - {1'h0, pop};
		end
	end

	// storage needs no reset, gated by count
	always_ff @(posedge clock) begin
		if (push) begin
			store[wptr] <= in_data;
		end
	end
endmodule : ssp_fifo2

// ----------------------------------------------------------------
// sram core and pin control
// ----------------------------------------------------------------
module ssp_pin_control
	import ssp_pkg::*;
(
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst,
	// controller command pins
	input  wire logic                    clock_qualify_n,
	input  wire logic                    chip_sel_first_n,
	input  wire logic                    chip_sel_second,
	input  wire logic                    chip_sel_third_n,
	input  wire logic                    write_n,
	input  wire logic                    advance_or_load,
	input  wire logic [`SSP_LANES-1:0]   byte_write_sel_n,
	input  wire logic [`SSP_AW-1:0]      addr,
	// asynchronous and static pins
	input  wire logic                    output_enable_n,
	input  wire logic                    burst_mode,
	// data pins
	input  wire ssp_pkg::ssp_word_t      dq_in,
	output var ssp_pkg::ssp_word_t       dq_out,
	output logic                         dq_oe
);
	import ssp_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ssp_word_t   mem [0:`SSP_DEPTH-1];
	ssp_cmd_t    cmd_a;
	ssp_cmd_t    cmd_b;
	ssp_wr_t     hold;
	logic        hold_valid;
	logic        read_phase;
	logic        oe_s1;
	logic        oe_s2;
	logic        mode_s1;
	logic        mode_s2;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// burst address, interleaved or linear
	function automatic logic [`SSP_AW-1:0] burst_addr(
		input ssp_cmd_t c,
		input logic     interleave
	);
		logic [`SSP_BURST_W-1:0] low;
		low = interleave ? (c.base[`SSP_BURST_W-1:0] ^ c.cnt)
			: (c.base[`SSP_BURST_W-1:0] + c.cnt);
		return {c.base[`SSP_AW-1:`SSP_BURST_W], low};
	endfunction : burst_addr

	// lane merge under active-low byte selects
	function automatic ssp_word_t lane_merge(
		input ssp_word_t              old_w,
		input ssp_word_t              new_w,
		input logic [`SSP_LANES-1:0]  sel_n
	);
		ssp_word_t r;
		r = old_w;
		for (int i = 0; i < `SSP_LANES; i++) begin
			if (!sel_n[i]) begin
				r[i*`SSP_LANE_W +: `SSP_LANE_W] =
					new_w[i*`SSP_LANE_W +: `SSP_LANE_W];
			end
		end
		return r;
	endfunction : lane_merge

	// ----------------------------------------------------------------
	// qualification and selection
	// ----------------------------------------------------------------
	// a full read buffer stalls the pipeline like a high qualify
	logic buf_in_ready;
	wire  step     = ~clock_qualify_n & buf_in_ready;
	wire  selected = ~chip_sel_first_n & chip_sel_second
		& ~chip_sel_third_n;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	// advance continues the last command; after deselect it stays idle
	ssp_cmd_t next_cmd_a;
	assign next_cmd_a.active = advance_or_load ? cmd_a.active
		: selected;
	assign next_cmd_a.wr     = advance_or_load ? cmd_a.wr
		: ~write_n;
	assign next_cmd_a.base   = advance_or_load ? cmd_a.base : addr;
	assign next_cmd_a.cnt    = advance_or_load
		? cmd_a.cnt + `SSP_BURST_W'(1) : '0;
	assign next_cmd_a.bws_n  = byte_write_sel_n;

	wire b_read  = cmd_b.active & ~cmd_b.wr;
	wire b_write = cmd_b.active & cmd_b.wr;
	wire a_read  = cmd_a.active & ~cmd_a.wr;

	wire [`SSP_AW-1:0] addr_a = burst_addr(cmd_a, mode_s2);
	wire [`SSP_AW-1:0] addr_b = burst_addr(cmd_b, mode_s2);

	// ----------------------------------------------------------------
	// array read with forwarding of writes not yet committed
	// ----------------------------------------------------------------
	// the hold register and the write now on the pins are both newer
	// than the array, so they overlay it in age order
	wire       hit_hold = hold_valid & (hold.addr == addr_a);
	wire       hit_pins = b_write & (addr_b == addr_a);
	ssp_word_t word_arr;
	ssp_word_t word_fwd1;
	ssp_word_t word_rd;
	assign word_arr  = mem[addr_a];
	assign word_fwd1 = hit_hold
		? lane_merge(word_arr, hold.data, hold.bws_n) : word_arr;
	assign word_rd   = hit_pins
		? lane_merge(word_fwd1, dq_in, cmd_b.bws_n) : word_fwd1;

	// ----------------------------------------------------------------
	// read buffer between the array and the output register
	// ----------------------------------------------------------------
	ssp_word_t buf_out_data;
	logic      buf_out_valid;
	wire       buf_push = step & a_read;
	wire       buf_pop  = step & b_read;

	ssp_fifo2 #(
		.W (`SSP_DW)
	) u_rd_buf (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (buf_push),
		.in_ready  (buf_in_ready),
		.in_data   (word_rd),
		.out_valid (buf_out_valid),
		.out_ready (buf_pop),
		.out_data  (buf_out_data)
	);

	// ----------------------------------------------------------------
	// next values of output control
	// ----------------------------------------------------------------
	// drive only in a read data phase with output enable low;
	// write data phase and deselect leave read_phase low
	wire next_read_phase = step ? (b_read & buf_out_valid)
		: read_phase;
	wire next_drive = next_read_phase & ~oe_s2;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// output enable is asynchronous; the strap is static but still
	// comes from outside, so both pass two flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			oe_s1   <= `SSP_OE_N_RST;
			oe_s2   <= `SSP_OE_N_RST;
			mode_s1 <= `SSP_MODE_RST;
			mode_s2 <= `SSP_MODE_RST;
		end else begin
			oe_s1   <= output_enable_n;
			oe_s2   <= oe_s1;
			mode_s1 <= burst_mode;
			mode_s2 <= mode_s1;
		end
	end

	// ----------------------------------------------------------------
	// command pipeline
	// ----------------------------------------------------------------
	// held whole while qualify is high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmd_a <= '0;
			cmd_b <= '0;
		end else if (step) begin
			cmd_a <= next_cmd_a;
			cmd_b <= cmd_a;
		end
	end

	// ----------------------------------------------------------------
	// write data capture
	// ----------------------------------------------------------------
	// data arrives two edges after its command
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hold_valid <= 1'h0;
			hold       <= '0;
		end else begin
			hold_valid <= step & b_write;
			if (step & b_write) begin
				hold.addr  <= addr_b;
				hold.data  <= dq_in;
				hold.bws_n <= cmd_b.bws_n;
			end
		end
	end

	// ----------------------------------------------------------------
	// array commit
	// ----------------------------------------------------------------
	// one edge after capture; the array itself has no reset
	always_ff @(posedge clock) begin
		if (hold_valid) begin
			mem[hold.addr] <= lane_merge(mem[hold.addr], hold.data,
				hold.bws_n);
		end
	end

	// ----------------------------------------------------------------
	// output register and drive
	// ----------------------------------------------------------------
	// read data stays put while qualify is high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dq_out     <= `SSP_WORD_RST;
			read_phase <= 1'h0;
			dq_oe      <= 1'h0;
		end else begin
			if (buf_pop) begin
				dq_out <= buf_out_data;
			end
			read_phase <= next_read_phase;
			dq_oe      <= next_drive;
		end
	end

endmodule : ssp_pin_control

`default_nettype wire

// *** ssp_pin_control_bench.sv ***
// self-checking bench of the sram pin-control block
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defines.svh"
// ----------
// bench
// ----------
module ssp_pin_control_bench;
	import ssp_pkg::*;
	typedef struct packed {logic c; logic o; ssp_word_t d;} ssp_exp_t;
	logic clock = 1'h0, rst = 1'h1, oe_n = 1'h0, mode = 1'h1;
	wire logic qn, wr_n, adv, dq_oe;
	wire logic [2:0] sel;
	wire logic [`SSP_LANES-1:0] bws_n;
	wire logic [`SSP_AW-1:0] a;
	wire ssp_word_t dq_in, dq_out;
	ssp_word_t mem [int];
	ssp_exp_t e0 = '0, e1 = '0, e2 = '0, e3 = '0;
	int n_fail = 0, checks_done = 0, cyc = 0;
	always #50 clock = ~clock;
	ssp_ctl_model ctl (.clock(clock), .qn(qn), .sel(sel), .wr_n(wr_n),
		.adv(adv), .bws_n(bws_n), .a(a), .dq(dq_in));
	ssp_pin_control DUT (.clock(clock), .rst(rst), .clock_qualify_n(qn),
		.chip_sel_first_n(sel[2]), .chip_sel_second(sel[1]),
		.chip_sel_third_n(sel[0]), .write_n(wr_n), .advance_or_load(adv),
		.byte_write_sel_n(bws_n), .addr(a), .output_enable_n(oe_n),
		.burst_mode(mode), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	task automatic results;
		if (n_fail == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	task automatic chk(input string nm, input ssp_word_t ex, ssp_word_t got);
		checks_done++;
		if (got !== ex) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, ex, got);
		end
	endtask : chk
	// expectations step only on qualified edges, like the pipeline
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			results();
		end
		if (!qn) begin
			e1 <= e0;
			e2 <= e1;
			e3 <= e2;
		end
	end
	// judged on every low phase, so a stall is re-checked each cycle
	always @(negedge clock) if (e3.c) begin
		chk("dq_oe", {31'h0, e3.o}, {31'h0, dq_oe});
		if (e3.o)
			chk("dq_out", e3.d, dq_out);
	end
	task automatic cmd(input logic [2:0] s, input logic w, input logic v,
		input logic [`SSP_AW-1:0] ad, input logic [3:0] b,
		input ssp_word_t d, input logic c, input logic o);
		ctl.issue(s, w, v, ad, b, d);
		e0 <= '{c, o, d};
	endtask : cmd
	// the mirror merges only lanes whose select is low
	task automatic wr(input logic [9:0] ad, input logic [3:0] b,
		input ssp_word_t d);
		for (int i = 0; i < `SSP_LANES; i++)
			if (!b[i])
				mem[ad][`SSP_LANE_W*i+:`SSP_LANE_W] = d[8*i+:8];
		cmd(3'h2, 1'h1, 1'h0, ad, b, d, 1'h1, 1'h0);
	endtask : wr
	task automatic rd(input logic [9:0] ad, input logic o);
		cmd(3'h2, 1'h0, 1'h0, ad, 4'hF, mem[ad], 1'h1, o);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) cmd(3'h6, 1'h0, 1'h0, 10'h0, 4'hF, 32'h0, 1'h0, 1'h0);
	endtask : idle
	task automatic t_rw;
		wr(10'h005, 4'h0, 32'h11223344);
		wr(10'h006, 4'h0, 32'hAABBCCDD);
		wr(10'h006, 4'hA, 32'h55667788);
		rd(10'h006, 1'h1);
		rd(10'h005, 1'h1);
		wr(10'h005, 4'h5, 32'h99AABBCC);
		rd(10'h005, 1'h1);
		idle(4);
	endtask : t_rw
	task automatic t_oe;
		oe_n <= 1'h1;
		idle(4);
		rd(10'h005, 1'h0);
		idle(3);
		oe_n <= 1'h0;
		idle(4);
	endtask : t_oe
	task automatic t_desel;
		for (int i = 0; i < 3; i++)
			cmd(3'h2 ^ (3'h1 << i), 1'h0, 1'h0, 10'h5, 4'hF, 0, 1'h1, 1'h0);
		cmd(3'h2, 1'h0, 1'h1, 10'h5, 4'hF, 0, 1'h1, 1'h0);
		idle(4);
	endtask : t_desel
	// stall lands while a read word is on the pins, so it must stay
	task automatic t_stall;
		rd(10'h006, 1'h1);
		rd(10'h005, 1'h1);
		rd(10'h006, 1'h1);
		ctl.stall(6);
		rd(10'h005, 1'h1);
		idle(4);
	endtask : t_stall
	task automatic t_burst;
		logic [9:0] b;
		for (int md = 1; md >= 0; md--) begin
			mode <= md[0];
			idle(4);
			for (int k = 0; k < 4; k++) begin
				b = {8'h40, md[0] ? 2'h1 ^ k[1:0] : 2'h1 + k[1:0]};
				mem[b] = 32'hC0DE0000 + k;
				cmd(3'h2, 1'h1, k != 0, 10'h101, 4'h0, mem[b], 1'h1, 1'h0);
			end
			for (int k = 0; k < 4; k++)
				rd({8'h40, k[1:0]}, 1'h1);
			// read burst walks the same order as the write burst
			for (int k = 0; k < 4; k++) begin
				b = {8'h40, md[0] ? 2'h1 ^ k[1:0] : 2'h1 + k[1:0]};
				cmd(3'h2, 1'h0, k != 0, 10'h101, 4'hF, mem[b],
					1'h1, 1'h1);
			end
			idle(4);
		end
	endtask : t_burst
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'h0;
		t_rw();
		t_oe();
		t_desel();
		t_stall();
		t_burst();
		results();
	end
endmodule : ssp_pin_control_bench
bind ssp_pin_control ssp_checker chk_i (.clock(clock), .rst(rst),
	.clock_qualify_n(clock_qualify_n), .chip_sel_first_n(chip_sel_first_n),
	.chip_sel_second(chip_sel_second), .chip_sel_third_n(chip_sel_third_n),
	.write_n(write_n), .advance_or_load(advance_or_load),
	.output_enable_n(output_enable_n), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

// *** ssp_pkg.sv ***
// types shared by the synchronous sram pin-control block
`include "ssp_defines.svh"

package ssp_pkg;

	// ----------------------------------------------------------------
	// data word and pipelined command
	// ----------------------------------------------------------------
	typedef logic [`SSP_DW-1:0] ssp_word_t;

	typedef struct packed {
		logic                     active;
		logic                     wr;
		logic [`SSP_AW-1:0]       base;
		logic [`SSP_BURST_W-1:0]  cnt;
		logic [`SSP_LANES-1:0]    bws_n;
	} ssp_cmd_t;

	// pending write waiting for its commit to the array
	typedef struct packed {
		logic [`SSP_AW-1:0]       addr;
		ssp_word_t                data;
		logic [`SSP_LANES-1:0]    bws_n;
	} ssp_wr_t;

endpackage : ssp_pkg
